// file: pkg/bsr_pkg.sv
// Shared constants for the burst SRAM device model
package bsr_pkg;
   localparam int WORD_W = 18;
   localparam int ADDR_W = 8;
   localparam int LANE_W = 9;
   localparam int BURST_LEN = 4;
   localparam int FIFO_DEPTH = 16;
   localparam logic [1:0] BEAT_FIRST = 2'h0;
   localparam logic [1:0] BEAT_LAST = 2'h3;
   localparam logic [2:0] SYNC_RESET = 3'h0;
   typedef enum logic [1:0] {PORT_IDLE, PORT_READ, PORT_WRITE} bsr_last_e;
endpackage

// file: pkg/bsr_fifo_if.sv
// Valid/ready stream carrier between the core and its read-data buffer
`timescale 1ns/1ps
interface bsr_fifo_if #(parameter int W = 18);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// file: verilog/bsr_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module bsr_fifo #(
   parameter int W = 18,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic srst,
   bsr_fifo_if.snk inPort,
   bsr_fifo_if.src outPort
);
   localparam int AW = $clog2(DEPTH);
   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("DEPTH must be a power of two, at least 2");
   end
   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic full, empty, push, pop;
   always_comb
   begin
      empty = (wrPtr_q == rdPtr_q);
      full = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) && (wrPtr_q[AW] != rdPtr_q[AW]);
      inPort.ready = !full;
      outPort.valid = !empty;
      outPort.data = mem_q[rdPtr_q[AW-1:0]];
      push = inPort.valid && !full;
      pop = outPort.ready && !empty;
      wrPtr_d = wrPtr_q + (AW+1)'(push);
      rdPtr_d = rdPtr_q + (AW+1)'(pop);
   end
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end
      else
      begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
      end
      if (push)
         mem_q[wrPtr_q[AW-1:0]] <= inPort.data;
   end
endmodule

// file: verilog/bsr_sram.sv
// Dual-port burst-of-four SRAM device: sampled link clocks, read and write ports
// Functional notes
// (R1) Accesses start only at positive clock rise
// (R2) Inputs sampled on both input clock rises
// (R3) Single clock mode: reads launch on input pair
// (R4) Four words per access over two cycles
// (R5) Output timing follows output or input pair
// (R6) Write data registered on input clock rises
// (R7) Read data registered on output clock rises
// (R8) Selects and lane gates registered on inputs
// (R9) Shared address bus, read and write multiplexed
// (R10) Separate read and write data ports
// (R11) Write select low starts write, else ignored
// (R12) Lane gate low writes lane, else unchanged
// (R13) Deselected read finishes, then outputs float
`timescale 1ns/1ps
module bsr_sram #(
   parameter int WORD_W = bsr_pkg::WORD_W,
   parameter int ADDR_W = bsr_pkg::ADDR_W
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic kClk,
   input wire logic kClkN,
   input wire logic cClk,
   input wire logic cClkN,
   input wire logic read_select_n,
   input wire logic write_select_n,
   input wire logic [WORD_W/bsr_pkg::LANE_W-1:0] lane_write_gate_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [WORD_W-1:0] wrData,
   output logic [WORD_W-1:0] rdData,
   output logic rdDataOe,
   output logic singleClock
);
   localparam int LANES = WORD_W / bsr_pkg::LANE_W;
   initial
   begin
      if (LANES < 1 || WORD_W % bsr_pkg::LANE_W != 0 || ADDR_W < 1)
         $error("WORD_W must be a multiple of the lane width");
   end
   // Two-flop synchronisers on every pin
   localparam int PW = 4 + 2 + LANES + ADDR_W + WORD_W;
   logic [PW-1:0] s1_q, s2_q, s3_q;
   always_ff @(posedge ref_clk)
   begin
      s1_q <= {kClk, kClkN, cClk, cClkN, read_select_n, write_select_n, lane_write_gate_n,
         addr, wrData};
      s2_q <= s1_q;
      s3_q <= s2_q;
   end
   logic kRise, knRise, cRise, cnRise;
   logic rdSel, wrSel;
   logic [LANES-1:0] gateN;
   logic [ADDR_W-1:0] addrS;
   logic [WORD_W-1:0] dS;
   logic outRise, outRiseN;
   logic strapDone_q, single_q;
   // Edges are ignored until the clock mode strap has been sampled after reset
   always_comb
   begin
      kRise = strapDone_q && s2_q[PW-1] && !s3_q[PW-1];
      knRise = strapDone_q && s2_q[PW-2] && !s3_q[PW-2];
      cRise = strapDone_q && s2_q[PW-3] && !s3_q[PW-3];
      cnRise = strapDone_q && s2_q[PW-4] && !s3_q[PW-4];
      rdSel = !s2_q[PW-5]; // R8
      wrSel = !s2_q[PW-6]; // R8
      gateN = s2_q[PW-7 -: LANES]; // R8
      addrS = s2_q[WORD_W +: ADDR_W];
      dS = s2_q[WORD_W-1:0];
      outRise = singleClock ? kRise : cRise; // R3 R5
      outRiseN = singleClock ? knRise : cnRise; // R3 R5
   end
   // Strap: both output clocks high shortly after reset selects single clock mode
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         strapDone_q <= 1'b0;
         single_q <= 1'b0;
      end
      else if (!strapDone_q)
      begin
         strapDone_q <= 1'b1;
         single_q <= s2_q[PW-3] && s2_q[PW-4];
      end
   end
   assign singleClock = single_q;
   // Port scheduler and write path
   logic [WORD_W-1:0] mem_q [(1<<ADDR_W)*bsr_pkg::BURST_LEN];
   bsr_pkg::bsr_last_e last_q, last_d;
   logic wrAct_q, wrAct_d, rdAct_q, rdAct_d;
   logic [1:0] wrBeat_q, wrBeat_d;
   logic [ADDR_W-1:0] wrAddr_q, wrAddr_d, rdAddr_q, rdAddr_d;
   logic wrWait_q, wrWait_d;
   logic doRead, doWrite, memWe, capEdge;
   logic [WORD_W-1:0] memWd;
   logic [ADDR_W+1:0] memIdx;
   bsr_fifo_if #(.W(WORD_W)) toFifo ();
   bsr_fifo_if #(.W(WORD_W)) fromFifo ();
   logic [1:0] rdBeat_q, rdBeat_d;
   always_comb
   begin
      last_d = last_q;
      wrAct_d = wrAct_q;
      wrBeat_d = wrBeat_q;
      wrAddr_d = wrAddr_q;
      wrWait_d = wrWait_q;
      rdAct_d = rdAct_q;
      rdAddr_d = rdAddr_q;
      rdBeat_d = rdBeat_q;
      doRead = 1'b0;
      doWrite = 1'b0;
      memWe = 1'b0;
      memWd = mem_q[{wrAddr_q, wrBeat_q}];
      memIdx = {wrAddr_q, wrBeat_q};
      capEdge = (kRise || knRise) && wrAct_q && !wrWait_q; // R2 R6
      toFifo.valid = 1'b0;
      toFifo.data = mem_q[{rdAddr_q, rdBeat_q}];
      if (kRise) // R1
      begin
         // A port that started last rise cannot start again; ports alternate
         if (rdSel && !rdAct_q && last_q != bsr_pkg::PORT_READ) // R1 R9
            doRead = 1'b1;
         else if (wrSel && !wrAct_q && last_q != bsr_pkg::PORT_WRITE) // R11 R9
            doWrite = 1'b1;
         last_d = doRead ? bsr_pkg::PORT_READ :
            (doWrite ? bsr_pkg::PORT_WRITE : bsr_pkg::PORT_IDLE);
      end
      if (doRead)
      begin
         rdAct_d = 1'b1;
         rdAddr_d = addrS;
         rdBeat_d = bsr_pkg::BEAT_FIRST;
      end
      if (doWrite)
      begin
         wrAct_d = 1'b1;
         wrWait_d = 1'b1;
         wrAddr_d = addrS;
         wrBeat_d = bsr_pkg::BEAT_FIRST;
      end
      // Skip only the kClkN rise of the start cycle; the first beat is the next kClk rise
      else if (knRise && wrWait_q)
         wrWait_d = 1'b0;
      if (capEdge)
      begin
         memWe = 1'b1;
         for (int i = 0; i < LANES; i++)
         begin
            if (!gateN[i]) // R12
               memWd[i*bsr_pkg::LANE_W +: bsr_pkg::LANE_W] = dS[i*bsr_pkg::LANE_W +:
                  bsr_pkg::LANE_W];
         end
         wrBeat_d = wrBeat_q + 2'h1; // R4
         if (wrBeat_q == bsr_pkg::BEAT_LAST)
            wrAct_d = 1'b0;
      end
      // Read words enter the buffer one per ref_clk, stalled by back-pressure
      if (rdAct_q && !doRead)
      begin
         toFifo.valid = 1'b1;
         if (toFifo.ready)
         begin
            rdBeat_d = rdBeat_q + 2'h1; // R4
            if (rdBeat_q == bsr_pkg::BEAT_LAST)
               rdAct_d = 1'b0;
         end
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         last_q <= bsr_pkg::PORT_IDLE;
         wrAct_q <= 1'b0;
         wrWait_q <= 1'b0;
         wrBeat_q <= bsr_pkg::BEAT_FIRST;
         wrAddr_q <= '0;
         rdAct_q <= 1'b0;
         rdBeat_q <= bsr_pkg::BEAT_FIRST;
         rdAddr_q <= '0;
      end
      else
      begin
         last_q <= last_d;
         wrAct_q <= wrAct_d;
         wrWait_q <= wrWait_d;
         wrBeat_q <= wrBeat_d;
         wrAddr_q <= wrAddr_d;
         rdAct_q <= rdAct_d;
         rdBeat_q <= rdBeat_d;
         rdAddr_q <= rdAddr_d;
      end
      if (memWe)
         mem_q[memIdx] <= memWd; // R6 R10
   end
   bsr_fifo #(.W(WORD_W), .DEPTH(bsr_pkg::FIFO_DEPTH)) rdBuf (
      .ref_clk(ref_clk),
      .srst(srst),
      .inPort(toFifo),
      .outPort(fromFifo)
   );
   // Output register: one word per output clock rise, float after drain
   logic [WORD_W-1:0] rdData_q, rdData_d;
   logic oe_q, oe_d;
   always_comb
   begin
      rdData_d = rdData_q;
      oe_d = oe_q;
      fromFifo.ready = 1'b0;
      if (outRise || outRiseN) // R7
      begin
         if (fromFifo.valid)
         begin
            fromFifo.ready = 1'b1;
            rdData_d = fromFifo.data;
            oe_d = 1'b1;
         end
         else if (outRise)
            oe_d = 1'b0; // R13
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         rdData_q <= '0;
         oe_q <= 1'b0;
      end
      else
      begin
         rdData_q <= rdData_d;
         oe_q <= oe_d;
      end
   end
   assign rdData = rdData_q; // R10
   assign rdDataOe = oe_q;
endmodule

// file: dv/bsr_sram_monitor.sv
// Port assertions for the burst SRAM device
`timescale 1ns/1ps
module bsr_sram_monitor #(parameter int WORD_W = 18) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic kClk,
   input wire logic kClkN,
   input wire logic cClk,
   input wire logic cClkN,
   input wire logic read_select_n,
   input wire logic [WORD_W-1:0] rdData,
   input wire logic rdDataOe,
   input wire logic singleClock
);
   logic [7:0] pins_q, pins_d;
   logic [5:0] age_q, age_d, idle_q, idle_d;
   wire logic pinRise = |(pins_q[3:0] & ~pins_q[7:4]);
   always_comb
   begin
      pins_d = {pins_q[3:0], kClk, kClkN, cClk, cClkN};
      age_d = srst ? 6'h3f : (pinRise ? 6'h0 : age_q + {5'h0, age_q != 6'h3f});
      idle_d = (srst || !read_select_n) ? 6'h0 : idle_q + {5'h0, idle_q != 6'h3f};
   end
   always_ff @(posedge ref_clk)
   begin
      pins_q <= pins_d;
      age_q <= age_d;
      idle_q <= idle_d;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   property p_rst_quiet; $past(srst) |-> !rdDataOe && rdData == '0; endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
   property p_on_edge; $changed(rdData) |-> age_q <= 6'h5; endproperty
   a_on_edge: assert property (p_on_edge) else $error("read word off clock rise");
   property p_from_read; $rose(rdDataOe) |-> idle_q <= 6'h18; endproperty
   a_from_read: assert property (p_from_read) else $error("drive without read");
   property p_float; idle_q > 6'h28 |-> !rdDataOe; endproperty
   a_float: assert property (p_float) else $error("outputs not released");
   property p_burst; $rose(rdDataOe) |-> rdDataOe [*8]; endproperty
   a_burst: assert property (p_burst) else $error("burst cut short");
   property p_stands; rdDataOe && $changed(rdData) |=> $stable(rdData) [*2]; endproperty
   a_stands: assert property (p_stands) else $error("word not held");
   property p_strap;
      !$past(srst) && !$past(srst, 2) && !$past(srst, 3)
         |-> $stable(singleClock) && singleClock == (cClk && cClkN);
   endproperty
   a_strap: assert property (p_strap) else $error("clock mode strap wrong");
   property p_drop; $fell(rdDataOe) |-> age_q <= 6'h5; endproperty
   a_drop: assert property (p_drop) else $error("release off clock rise");
   c_start: cover property ($rose(rdDataOe));
   c_end: cover property ($fell(rdDataOe));
   c_word: cover property (singleClock && $changed(rdData));
   c_dual: cover property (!singleClock && $rose(rdDataOe));
endmodule

// file: dv/bsr_ctrl_model.sv
// Controller model: free input clock pair and burst access tasks
`timescale 1ns/1ps
module bsr_ctrl_model (
   input wire logic ref_clk,
   input wire logic [17:0] rdData,
   input wire logic rdDataOe,
   output logic kClk,
   output logic kClkN,
   output logic cClk,
   output logic cClkN,
   output logic read_select_n,
   output logic write_select_n,
   output logic [1:0] lane_write_gate_n,
   output logic [7:0] addr,
   output logic [17:0] wrData
);
   assign kClkN = ~kClk;
   initial
   begin
      // Both selects and both lane gates idle high from time zero
      {kClk, read_select_n, write_select_n, lane_write_gate_n, addr, wrData} = 31'h3c000000;
      #1;
      forever #16 kClk = ~kClk;
   end
   // Output clock pair: tied high for single clock mode, else kClk delayed by 4 ns
   logic cRun = 1'b0;
   initial
   begin
      {cClk, cClkN} = 2'h3;
      forever
      begin
         @(kClk);
         {cClk, cClkN} <= #4 cRun ? {kClk, ~kClk} : 2'h3;
      end
   end
   task automatic step(input logic neg);
      if (neg)
         @(posedge kClkN);
      else
         @(posedge kClk);
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [71:0] d, input logic [7:0] g);
      step(1'b1);
      write_select_n = 1'b0;
      addr = a;
      step(1'b0);
      write_select_n = 1'b1;
      addr = ~a;
      for (int i = 0; i < 4; i++)
      begin
         wrData = d[18*i +: 18];
         lane_write_gate_n = g[2*i +: 2];
         step(i[0]);
      end
      wrData = ~wrData;
      lane_write_gate_n = ~lane_write_gate_n;
   endtask
   task automatic rd(input logic [7:0] a, input logic hold, output logic [71:0] q,
      output logic [3:0] oe);
      realtime t0;
      step(1'b1);
      read_select_n = 1'b0;
      addr = a;
      @(posedge kClk);
      t0 = $realtime;
      repeat (2) @(negedge ref_clk);
      read_select_n = hold;
      addr = ~a;
      for (int i = 0; i < 4; i++)
      begin
         #(t0 + 16.0 * (i + 1) + 20.0 - $realtime);
         q[18*i +: 18] = rdData;
         oe[i] = rdDataOe;
         read_select_n = 1'b1;
      end
   endtask
endmodule

// file: dv/dual_port_burst_sram_interface_tb.sv
// Self-checking bench for the burst SRAM device
`timescale 1ns/1ps
module dual_port_burst_sram_interface_tb;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic kClk, kClkN, cClk, cClkN, read_select_n, write_select_n, rdDataOe, singleClock;
   logic [1:0] lane_write_gate_n;
   logic [7:0] addr;
   logic [17:0] wrData, rdData;
   logic [17:0] mem [1024];
   int error_cnt = 0;
   int n_compared = 0;
   always #2 ref_clk = ~ref_clk;
   bsr_sram u_bsr_sram (.ref_clk, .srst, .kClk, .kClkN, .cClk, .cClkN, .read_select_n,
      .write_select_n, .lane_write_gate_n, .addr, .wrData, .rdData, .rdDataOe, .singleClock);
   bsr_ctrl_model u_bsr_ctrl_model (.ref_clk, .rdData, .rdDataOe, .kClk, .kClkN, .cClk,
      .cClkN, .read_select_n, .write_select_n, .lane_write_gate_n, .addr, .wrData);
   function automatic logic [17:0] merge(logic [17:0] old, logic [17:0] nw, logic [1:0] g);
      return {g[1] ? old[17:9] : nw[17:9], g[0] ? old[8:0] : nw[8:0]};
   endfunction
   task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #20000;
      error_cnt++;
      $display("BAD %0t watchdog expired", $time);
      print_verdict();
   end
   initial
   begin
      logic [71:0] d, q;
      logic [7:0] a, g;
      logic [3:0] oe;
      void'($urandom(61174));
      repeat (2) @(negedge ref_clk);
      srst = 1'b0;
      repeat (4) @(negedge ref_clk);
      cmp({17'h0, singleClock}, 18'h1);
      for (int k = 0; k < 17; k++)
      begin
         if (k == 14)
         begin
            // Mid-run reset with the output clock pair running: dual clock mode
            @(negedge ref_clk);
            srst = 1'b1;
            u_bsr_ctrl_model.cRun = 1'b1;
            repeat (12) @(negedge ref_clk);
            srst = 1'b0;
            repeat (4) @(negedge ref_clk);
            cmp({17'h0, singleClock}, 18'h0);
            cmp({17'h0, rdDataOe}, 18'h0);
         end
         a = (k % 7 == 0) ? 8'hff : 8'(k % 7);
         d = {8'($urandom), $urandom, $urandom};
         g = (k < 7) ? 8'h0 : 8'($urandom);
         u_bsr_ctrl_model.wr(a, d, g);
         for (int i = 0; i < 4; i++)
            mem[{a, 2'(i)}] = merge(mem[{a, 2'(i)}], d[18*i +: 18], g[2*i +: 2]);
         u_bsr_ctrl_model.rd(a, k[0], q, oe);
         for (int i = 0; i < 4; i++)
         begin
            cmp(q[18*i +: 18], mem[{a, 2'(i)}]);
            cmp({17'h0, oe[i]}, 18'h1);
         end
         #42;
         cmp({17'h0, rdDataOe}, 18'h0);
      end
      print_verdict();
   end
endmodule
bind bsr_sram bsr_sram_monitor #(.WORD_W(WORD_W)) u_bsr_sram_monitor (.ref_clk, .srst, .kClk,
   .kClkN, .cClk, .cClkN, .read_select_n, .rdData, .rdDataOe, .singleClock);
